// [include/fsq_pkg.sv]
// Shared constants, types and step decoding for the flash command sequencer
package fsq_pkg;

  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;

  localparam logic [16:0] UNLOCK1_ADDR = 17'h05555;
  localparam logic [16:0] UNLOCK2_ADDR = 17'h02aaa;
  localparam logic [7:0]  UNLOCK1_DATA = 8'haa;
  localparam logic [7:0]  UNLOCK2_DATA = 8'h55;
  localparam logic [7:0]  CMD_RESET    = 8'hf0;
  localparam logic [7:0]  CMD_PROGRAM  = 8'ha0;
  localparam logic [7:0]  CMD_ERASE    = 8'h80;
  localparam logic [7:0]  CMD_CHIP     = 8'h10;
  localparam logic [7:0]  CMD_SECTOR   = 8'h30;

  localparam int COMPLETION_POLL_BIT = 7;
  localparam int OVERTIME_FLAG_BIT   = 5;

  localparam logic [2:0] RESET_LEN   = 3'h3;
  localparam logic [2:0] PROGRAM_LEN = 3'h4;
  localparam logic [2:0] ERASE_LEN   = 3'h6;

  localparam int CLK_PERIOD_NS  = 100;
  localparam int WE_PULSE_NS    = 50;
  localparam int ADDR_HOLD_NS   = 50;
  localparam int READ_ACCESS_NS = 150;

  localparam int WE_PULSE_CYC  = (WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ADDR_HOLD_CYC = (ADDR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_ACC_CYC  = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [2:0] CNT_ZERO = 3'h0;

  typedef enum logic [2:0]
  {
    FSQ_OP_READ         = 3'h0,
    FSQ_OP_PROGRAM      = 3'h1,
    FSQ_OP_CHIP_ERASE   = 3'h2,
    FSQ_OP_SECTOR_ERASE = 3'h3,
    FSQ_OP_RESET        = 3'h4
  } fsq_op_type;

  typedef enum logic [1:0]
  {
    FSQ_BC_IDLE   = 2'h0,
    FSQ_BC_SETUP  = 2'h1,
    FSQ_BC_STROBE = 2'h2,
    FSQ_BC_HOLD   = 2'h3
  } fsq_bc_state_type;

  typedef enum logic [2:0]
  {
    FSQ_SQ_IDLE   = 3'h0,
    FSQ_SQ_WRITE  = 3'h1,
    FSQ_SQ_WAIT_W = 3'h2,
    FSQ_SQ_POLL   = 3'h3,
    FSQ_SQ_WAIT_P = 3'h4
  } fsq_sq_state_type;

  function automatic logic [2:0] fsq_seq_len(input fsq_op_type op);
    case (op)
      FSQ_OP_RESET:   fsq_seq_len = RESET_LEN;
      FSQ_OP_PROGRAM: fsq_seq_len = PROGRAM_LEN;
      default:        fsq_seq_len = ERASE_LEN;
    endcase
  endfunction

  function automatic logic [16:0] fsq_step_addr(input fsq_op_type op, input logic [2:0] idx,
                                                input logic [16:0] target);
    case (idx)
      3'h1:    fsq_step_addr = UNLOCK2_ADDR;
      3'h3:    fsq_step_addr = (op == FSQ_OP_PROGRAM) ? target : UNLOCK1_ADDR;
      3'h4:    fsq_step_addr = UNLOCK2_ADDR;
      3'h5:    fsq_step_addr = (op == FSQ_OP_SECTOR_ERASE) ? target : UNLOCK1_ADDR;
      default: fsq_step_addr = UNLOCK1_ADDR;
    endcase
  endfunction

  function automatic logic [7:0] fsq_step_data(input fsq_op_type op, input logic [2:0] idx,
                                               input logic [7:0] value);
    case (idx)
      3'h1:    fsq_step_data = UNLOCK2_DATA;
      3'h2:    fsq_step_data = (op == FSQ_OP_RESET) ? CMD_RESET :
                               (op == FSQ_OP_PROGRAM) ? CMD_PROGRAM : CMD_ERASE;
      3'h3:    fsq_step_data = (op == FSQ_OP_PROGRAM) ? value : UNLOCK1_DATA;
      3'h4:    fsq_step_data = UNLOCK2_DATA;
      3'h5:    fsq_step_data = (op == FSQ_OP_SECTOR_ERASE) ? CMD_SECTOR : CMD_CHIP;
      default: fsq_step_data = UNLOCK1_DATA;
    endcase
  endfunction

endpackage

// [hdl/fsq_bus_cycle.sv]
// One asynchronous read or write cycle on the flash pins
`timescale 1ns/1ps
module fsq_bus_cycle
(
  input  wire  logic        clk_sys,
  input  wire  logic        reset,
  input  wire  logic        req_valid,
  input  wire  logic        req_write,
  input  wire  logic [16:0] req_addr,
  input  wire  logic [7:0]  req_data,
  output logic              req_ready,
  output logic              done,
  output logic [7:0]        rd_data,
  output logic              flash_ce_n,
  output logic              flash_oe_n,
  output logic              flash_we_n,
  output logic [16:0]       flash_addr,
  output logic [7:0]        flash_dq_out,
  output logic              flash_dq_oe,
  input  wire  logic [7:0]  flash_dq_in
);

  typedef struct packed
  {
    fsq_pkg::fsq_bc_state_type state;
    logic [2:0]                cnt;
    logic                      write;
    logic                      ce_n;
    logic                      oe_n;
    logic                      we_n;
    logic [16:0]               addr;
    logic [7:0]                dq_out;
    logic                      dq_oe;
    logic                      done;
    logic [7:0]                rd_data;
  } fsq_bc_type;

  fsq_bc_type st_ff;
  fsq_bc_type nxt_st;

  always_comb
  begin
    nxt_st      = st_ff;
    nxt_st.done = 1'b0;
    case (st_ff.state)
      fsq_pkg::FSQ_BC_IDLE:
      begin
        if (req_valid)
        begin
          nxt_st.state  = fsq_pkg::FSQ_BC_SETUP;
          nxt_st.write  = req_write;
          nxt_st.ce_n   = 1'b0;
          nxt_st.addr   = req_addr;
          nxt_st.dq_out = req_data;
          // Drive data only while the output gate is high
          nxt_st.dq_oe  = req_write;
        end
      end
      fsq_pkg::FSQ_BC_SETUP:
      begin
        nxt_st.state = fsq_pkg::FSQ_BC_STROBE;
        if (st_ff.write)
        begin
          nxt_st.we_n = 1'b0;
          nxt_st.cnt  = 3'(fsq_pkg::WE_PULSE_CYC - 1);
        end
        else
        begin
          nxt_st.oe_n = 1'b0;
          nxt_st.cnt  = 3'(fsq_pkg::READ_ACC_CYC - 1);
        end
      end
      fsq_pkg::FSQ_BC_STROBE:
      begin
        if (st_ff.cnt == fsq_pkg::CNT_ZERO)
        begin
          nxt_st.state = fsq_pkg::FSQ_BC_HOLD;
          nxt_st.cnt   = 3'(fsq_pkg::ADDR_HOLD_CYC - 1);
          nxt_st.we_n  = 1'b1;
          nxt_st.oe_n  = 1'b1;
          if (!st_ff.write)
          begin
            nxt_st.rd_data = flash_dq_in;
          end
        end
        else
        begin
          nxt_st.cnt = st_ff.cnt - 3'h1;
        end
      end
      fsq_pkg::FSQ_BC_HOLD:
      begin
        // Chip select rises after the strobe so the write strobe edge latches data
        if (st_ff.cnt == fsq_pkg::CNT_ZERO)
        begin
          nxt_st.state = fsq_pkg::FSQ_BC_IDLE;
          nxt_st.ce_n  = 1'b1;
          nxt_st.dq_oe = 1'b0;
          nxt_st.done  = 1'b1;
        end
        else
        begin
          nxt_st.cnt = st_ff.cnt - 3'h1;
        end
      end
      default:
      begin
        nxt_st = st_ff;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      st_ff <= '{state: fsq_pkg::FSQ_BC_IDLE, cnt: 3'h0, write: 1'b0, ce_n: 1'b1,
                 oe_n: 1'b1, we_n: 1'b1, addr: 17'h00000, dq_out: 8'h00,
                 dq_oe: 1'b0, done: 1'b0, rd_data: 8'h00};
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign req_ready    = (st_ff.state == fsq_pkg::FSQ_BC_IDLE);
  assign done         = st_ff.done;
  assign rd_data      = st_ff.rd_data;
  assign flash_ce_n   = st_ff.ce_n;
  assign flash_oe_n   = st_ff.oe_n;
  assign flash_we_n   = st_ff.we_n;
  assign flash_addr   = st_ff.addr;
  assign flash_dq_out = st_ff.dq_out;
  assign flash_dq_oe  = st_ff.dq_oe;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  write_strobe_a: assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n)
    else $error("Write strobe low without chip select low and gate high");
  no_fight_a: assert property (flash_dq_oe |-> flash_oe_n)
    else $error("Host drives data while output gate is low");
  strobe_width_a: assert property ($fell(flash_we_n) |-> ##1 flash_we_n && !flash_ce_n)
    else $error("Write strobe width or chip select hold wrong");
  read_window_a: assert property ($fell(flash_oe_n) |->
    !flash_oe_n ##1 !flash_oe_n ##1 flash_oe_n ##1 done)
    else $error("Read gate window or completion wrong");

  write_cycle_c: cover property ($fell(flash_we_n) ##[1:3] done);

endmodule

// [hdl/fsq_sequencer.sv]
// Host-side command sequencer that drives one byte-wide flash die
`timescale 1ns/1ps
// Summary of operation
// - Data appears on the pins only with select and gate low, strobe high.
// - Host writes by pulling strobe low with select low, gate high.
// - Each sequence starts with AA to 5555 then 55 to 2AAA.
// - Reset-to-read is F0 to 5555 as third write.
// - Byte program is unlock pair, A0 to 5555, then byte to target.
// - Host polls completion at the very location being programmed.
// - Chip erase: unlock, 80 to 5555, unlock, 10 to 5555.
// - Sector erase sixth write is 30 to an address in the sector.
module fsq_sequencer
#(
  parameter int POLL_LIMIT = 200000000
)
(
  input  wire  logic        clk_sys,
  input  wire  logic        reset,
  input  wire  logic        cmd_valid,
  output logic              cmd_ready,
  input  wire  logic [2:0]  cmd_op,
  input  wire  logic [16:0] cmd_addr,
  input  wire  logic [7:0]  cmd_data,
  output logic              resp_valid,
  output logic [7:0]        resp_data,
  output logic              resp_timeout,
  output logic              busy,
  output logic              flash_ce_n,
  output logic              flash_oe_n,
  output logic              flash_we_n,
  output logic [16:0]       flash_addr,
  output logic [7:0]        flash_dq_out,
  output logic              flash_dq_oe,
  input  wire  logic [7:0]  flash_dq_in
);

  typedef struct packed
  {
    fsq_pkg::fsq_sq_state_type state;
    fsq_pkg::fsq_op_type       op;
    logic [16:0]               addr;
    logic [7:0]                data;
    logic [2:0]                step;
    logic [7:0]                rdata;
    logic                      resp_valid;
    logic                      resp_timeout;
    logic                      timed_out;
    logic                      recheck;
    logic [27:0]               poll_cnt;
  } fsq_sq_type;

  fsq_sq_type  st_ff;
  fsq_sq_type  nxt_st;
  logic        req_valid;
  logic        req_write;
  logic [16:0] req_addr;
  logic [7:0]  req_data;
  logic        req_ready;
  logic        bc_done;
  logic [7:0]  bc_rd_data;
  logic        finished;

  // Write steps come from the shared table; polls always hit the target
  assign req_valid = (st_ff.state == fsq_pkg::FSQ_SQ_WRITE) ||
                     (st_ff.state == fsq_pkg::FSQ_SQ_POLL);
  assign req_write = (st_ff.state == fsq_pkg::FSQ_SQ_WRITE);
  assign req_addr  = req_write ? fsq_pkg::fsq_step_addr(st_ff.op, st_ff.step, st_ff.addr)
                               : st_ff.addr;
  assign req_data  = fsq_pkg::fsq_step_data(st_ff.op, st_ff.step, st_ff.data);

  // Program is done when bit 7 matches the written value, erase when it reads one
  assign finished = (st_ff.op == fsq_pkg::FSQ_OP_PROGRAM) ?
                    (bc_rd_data[fsq_pkg::COMPLETION_POLL_BIT] ==
                     st_ff.data[fsq_pkg::COMPLETION_POLL_BIT]) :
                    bc_rd_data[fsq_pkg::COMPLETION_POLL_BIT];

  always_comb
  begin
    nxt_st            = st_ff;
    nxt_st.resp_valid = 1'b0;
    case (st_ff.state)
      fsq_pkg::FSQ_SQ_IDLE:
      begin
        if (cmd_valid)
        begin
          nxt_st.op        = fsq_pkg::fsq_op_type'(cmd_op);
          nxt_st.addr      = cmd_addr;
          nxt_st.data      = cmd_data;
          nxt_st.step      = 3'h0;
          nxt_st.timed_out = 1'b0;
          nxt_st.recheck   = 1'b0;
          nxt_st.poll_cnt  = 28'h0000000;
          case (fsq_pkg::fsq_op_type'(cmd_op))
            fsq_pkg::FSQ_OP_PROGRAM,
            fsq_pkg::FSQ_OP_CHIP_ERASE,
            fsq_pkg::FSQ_OP_SECTOR_ERASE,
            fsq_pkg::FSQ_OP_RESET:
            begin
              nxt_st.state = fsq_pkg::FSQ_SQ_WRITE;
            end
            default:
            begin
              // Unknown codes fall back to a plain read, needing no command
              nxt_st.op    = fsq_pkg::FSQ_OP_READ;
              nxt_st.state = fsq_pkg::FSQ_SQ_POLL;
            end
          endcase
        end
      end
      fsq_pkg::FSQ_SQ_WRITE:
      begin
        if (req_ready)
        begin
          nxt_st.state = fsq_pkg::FSQ_SQ_WAIT_W;
        end
      end
      fsq_pkg::FSQ_SQ_WAIT_W:
      begin
        if (bc_done)
        begin
          nxt_st.step = st_ff.step + 3'h1;
          if ((st_ff.step + 3'h1) != fsq_pkg::fsq_seq_len(st_ff.op))
          begin
            nxt_st.state = fsq_pkg::FSQ_SQ_WRITE;
          end
          else if (st_ff.op == fsq_pkg::FSQ_OP_RESET)
          begin
            nxt_st.state        = fsq_pkg::FSQ_SQ_IDLE;
            nxt_st.resp_valid   = 1'b1;
            nxt_st.resp_timeout = st_ff.timed_out;
          end
          else
          begin
            // Self-timed work begins at the last strobe; no more pacing is needed
            nxt_st.state = fsq_pkg::FSQ_SQ_POLL;
          end
        end
      end
      fsq_pkg::FSQ_SQ_POLL:
      begin
        if (req_ready)
        begin
          nxt_st.state = fsq_pkg::FSQ_SQ_WAIT_P;
        end
      end
      fsq_pkg::FSQ_SQ_WAIT_P:
      begin
        if (bc_done)
        begin
          nxt_st.rdata = bc_rd_data;
          if ((st_ff.op == fsq_pkg::FSQ_OP_READ) || finished)
          begin
            nxt_st.state        = fsq_pkg::FSQ_SQ_IDLE;
            nxt_st.resp_valid   = 1'b1;
            nxt_st.resp_timeout = 1'b0;
          end
          else if (st_ff.recheck || (st_ff.poll_cnt == 28'(POLL_LIMIT)))
          begin
            // Failed operation: the reset sequence is the only way back to reads
            nxt_st.timed_out = 1'b1;
            nxt_st.op        = fsq_pkg::FSQ_OP_RESET;
            nxt_st.step      = 3'h0;
            nxt_st.state     = fsq_pkg::FSQ_SQ_WRITE;
          end
          else
          begin
            // Overtime seen: one more look at bit 7 decides, as it may have just ended
            nxt_st.recheck  = bc_rd_data[fsq_pkg::OVERTIME_FLAG_BIT];
            nxt_st.poll_cnt = st_ff.poll_cnt + 28'h0000001;
            nxt_st.state    = fsq_pkg::FSQ_SQ_POLL;
          end
        end
      end
      default:
      begin
        nxt_st.state = fsq_pkg::FSQ_SQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      st_ff <= '{state: fsq_pkg::FSQ_SQ_IDLE, op: fsq_pkg::FSQ_OP_READ, addr: 17'h00000,
                 data: 8'h00, step: 3'h0, rdata: 8'h00, resp_valid: 1'b0,
                 resp_timeout: 1'b0, timed_out: 1'b0, recheck: 1'b0, poll_cnt: 28'h0000000};
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign cmd_ready    = (st_ff.state == fsq_pkg::FSQ_SQ_IDLE);
  assign busy         = (st_ff.state != fsq_pkg::FSQ_SQ_IDLE);
  assign resp_valid   = st_ff.resp_valid;
  assign resp_data    = st_ff.rdata;
  assign resp_timeout = st_ff.resp_timeout;

  fsq_bus_cycle u_bus
  (
    .clk_sys      (clk_sys),
    .reset        (reset),
    .req_valid    (req_valid),
    .req_write    (req_write),
    .req_addr     (req_addr),
    .req_data     (req_data),
    .req_ready    (req_ready),
    .done         (bc_done),
    .rd_data      (bc_rd_data),
    .flash_ce_n   (flash_ce_n),
    .flash_oe_n   (flash_oe_n),
    .flash_we_n   (flash_we_n),
    .flash_addr   (flash_addr),
    .flash_dq_out (flash_dq_out),
    .flash_dq_oe  (flash_dq_oe),
    .flash_dq_in  (flash_dq_in)
  );

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  unlock_first_a: assert property (req_valid && req_write && st_ff.step == 3'h0 |->
    req_addr == 17'h05555 && req_data == 8'haa) else $error("First unlock write wrong");
  unlock_second_a: assert property (req_valid && req_write && st_ff.step == 3'h1 |->
    req_addr == 17'h02aaa && req_data == 8'h55) else $error("Second unlock write wrong");
  reset_word_a: assert property (req_write && st_ff.op == fsq_pkg::FSQ_OP_RESET &&
    st_ff.step == 3'h2 |-> req_addr == 17'h05555 && req_data == 8'hf0)
    else $error("Reset command word wrong");
  program_word_a: assert property (req_write && st_ff.op == fsq_pkg::FSQ_OP_PROGRAM &&
    st_ff.step == 3'h3 |-> req_addr == st_ff.addr && req_data == st_ff.data &&
    $past(st_ff.step) == 3'h2) else $error("Program target write wrong");
  chip_erase_a: assert property (req_write && st_ff.op == fsq_pkg::FSQ_OP_CHIP_ERASE &&
    st_ff.step == 3'h5 |-> req_addr == 17'h05555 && req_data == 8'h10)
    else $error("Chip erase command wrong");
  sector_erase_a: assert property (req_write && st_ff.op == fsq_pkg::FSQ_OP_SECTOR_ERASE &&
    st_ff.step == 3'h5 |-> req_addr == st_ff.addr && req_data == 8'h30)
    else $error("Sector erase command wrong");
  poll_location_a: assert property ($fell(flash_oe_n) |-> flash_addr == st_ff.addr)
    else $error("Poll read not at target location");
  read_latency_a: assert property (cmd_valid && cmd_ready && cmd_op == 3'h0 |->
    ##7 resp_valid && !resp_timeout) else $error("Plain read answer not on time");
  program_order_a: assert property (st_ff.state == fsq_pkg::FSQ_SQ_WAIT_W && bc_done &&
    st_ff.op == fsq_pkg::FSQ_OP_PROGRAM && st_ff.step == 3'h3 |-> ##1
    st_ff.state == fsq_pkg::FSQ_SQ_POLL ##1 !flash_ce_n)
    else $error("Polling did not follow the program write");

  program_done_c: cover property (resp_valid && st_ff.op == fsq_pkg::FSQ_OP_PROGRAM);
  erase_done_c: cover property (resp_valid && st_ff.op == fsq_pkg::FSQ_OP_SECTOR_ERASE);
  timeout_c: cover property (resp_valid && resp_timeout);
  read_done_c: cover property (resp_valid && st_ff.op == fsq_pkg::FSQ_OP_READ);

endmodule

// [test/fsq_flash_model.sv]
// Behavioural flash die that answers the command sequencer on its pins
`timescale 1ns/1ps
module fsq_flash_model
#(
  parameter int PROG_NS  = 1500,
  parameter int ERASE_NS = 4000
)
(
  input  wire  logic        ce_n,
  input  wire  logic        oe_n,
  input  wire  logic        we_n,
  input  wire  logic [16:0] addr,
  input  wire  logic [7:0]  dq_host,
  input  wire  logic        dq_host_oe,
  output logic [7:0]        dq,
  output int                errs
);
  logic [7:0]  mem [0:131071];
  logic [16:0] lat_a;
  logic [16:0] pa;
  logic [7:0]  pd;
  logic [2:0]  step;
  logic [2:0]  sec;
  logic        busy;
  logic        ovt;
  logic        erase;
  logic        all;
  logic        tog;
  logic [7:0]  rd_val;
  event        go;
  wire         wr_n = ce_n | we_n;
  // Bits 15 and 16 take no part in the unlock compare
  wire  [14:0] low  = lat_a[14:0];

  initial
  begin
    errs = 0;
    lat_a = 17'h00000;
    step = 3'h0;
    busy = 1'b0;
    ovt = 1'b0;
    erase = 1'b0;
    tog = 1'b0;
    for (int i = 0; i < 131072; i++)
      mem[i] = 8'(i * 7 + 3);
  end

  always @(negedge wr_n)
    lat_a = addr;

  always @(posedge wr_n)
    if (!oe_n)
      errs++;
    else if (!busy || ovt)
      take(dq_host);

  task automatic take(input logic [7:0] d);
    case (step)
      3'h0: step = (low == 15'h5555 && d == 8'haa) ? 3'h1 : 3'h0;
      3'h1: step = (low == 15'h2aaa && d == 8'h55) ? 3'h2 : 3'h0;
      3'h2:
      begin
        step = (low != 15'h5555) ? 3'h0 : (d == 8'ha0) ? 3'h3 : (d == 8'h80) ? 3'h4 : 3'h0;
        if (low == 15'h5555 && d == 8'hf0)
        begin
          ovt = 1'b0;
          busy = 1'b0;
        end
      end
      3'h3:
      begin
        step = 3'h0;
        pa = lat_a;
        pd = d;
        erase = 1'b0;
        busy = 1'b1;
        ovt = |(d & ~mem[pa]);
        if (ovt)
          mem[pa] = mem[pa] & d;
        else
          ->go;
      end
      3'h4: step = (low == 15'h5555 && d == 8'haa) ? 3'h5 : 3'h0;
      3'h5: step = (low == 15'h2aaa && d == 8'h55) ? 3'h6 : 3'h0;
      default:
      begin
        step = 3'h0;
        all = (low == 15'h5555 && d == 8'h10);
        sec = lat_a[16:14];
        if (all || d == 8'h30)
        begin
          erase = 1'b1;
          busy = 1'b1;
          ->go;
        end
      end
    endcase
  endtask

  always
  begin
    @(go);
    // Timer ignores the select line, so deselecting never aborts
    #(erase ? ERASE_NS : PROG_NS);
    for (int i = 0; i < 131072; i++)
      if (erase && (all || 3'(i >> 14) == sec))
      begin
        mem[i] = 8'h00;
        mem[i] = 8'hff;
      end
    if (!erase)
      mem[pa] = mem[pa] & pd;
    busy = 1'b0;
  end

  always @(negedge oe_n)
  begin
    if (dq_host_oe)
      errs++;
    if (busy && !ce_n)
      tog = ~tog;
  end

  always_comb
    if (busy)
      rd_val = {erase ? 1'b0 : ~pd[7], tog, ovt, 5'h00};
    else
      rd_val = mem[addr];

  // A floating bus shows the inverse so a stale value never passes
  assign dq = (!ce_n && !oe_n && we_n) ? rd_val : ~rd_val;
endmodule

// [test/tb_flash_bus_and_command_sequencer.sv]
// Self-checking bench for the flash command sequencer against a device model
`timescale 1ns/1ps
module tb_flash_bus_and_command_sequencer;
  localparam int LIM = 500;
  logic        clk_sys;
  logic        reset;
  logic        cmd_valid;
  logic        cmd_ready;
  logic [2:0]  cmd_op;
  logic [16:0] cmd_addr;
  logic [7:0]  cmd_data;
  logic        resp_valid;
  logic [7:0]  resp_data;
  logic        resp_timeout;
  logic        busy;
  logic        ce_n;
  logic        oe_n;
  logic        we_n;
  logic [16:0] f_addr;
  logic [7:0]  dq_out;
  logic        dq_oe;
  logic [7:0]  dq_in;
  int          model_errs;
  int          fail_count;
  int          compares;
  int          seed_v;
  logic [7:0]  ref_mem [0:131071];
  logic [16:0] a;
  logic [7:0]  d;

  fsq_sequencer #(.POLL_LIMIT(20)) uut
  (
    .clk_sys      (clk_sys),
    .reset        (reset),
    .cmd_valid    (cmd_valid),
    .cmd_ready    (cmd_ready),
    .cmd_op       (cmd_op),
    .cmd_addr     (cmd_addr),
    .cmd_data     (cmd_data),
    .resp_valid   (resp_valid),
    .resp_data    (resp_data),
    .resp_timeout (resp_timeout),
    .busy         (busy),
    .flash_ce_n   (ce_n),
    .flash_oe_n   (oe_n),
    .flash_we_n   (we_n),
    .flash_addr   (f_addr),
    .flash_dq_out (dq_out),
    .flash_dq_oe  (dq_oe),
    .flash_dq_in  (dq_in)
  );

  fsq_flash_model dev
  (
    .ce_n       (ce_n),
    .oe_n       (oe_n),
    .we_n       (we_n),
    .addr       (f_addr),
    .dq_host    (dq_out),
    .dq_host_oe (dq_oe),
    .dq         (dq_in),
    .errs       (model_errs)
  );

  always #50 clk_sys = ~clk_sys;

  task automatic err(input string msg);
    fail_count++;
    $display("ERROR at %0t: %s", $time, msg);
  endtask

  task automatic conclude();
    compares++;
    if (model_errs != 0)
      err("device model saw a bad pin sequence");
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic run(input logic [2:0] op, input logic [16:0] ad, input logic [7:0] dt,
                     input logic [7:0] ed, input logic et, input logic [7:0] m = 8'hff);
    int n;
    @(posedge clk_sys);
    cmd_op <= op;
    cmd_addr <= ad;
    cmd_data <= dt;
    cmd_valid <= 1'b1;
    n = 0;
    do
    begin
      @(negedge clk_sys);
      n++;
    end
    while (cmd_ready !== 1'b1 && n < LIM);
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    do
    begin
      @(negedge clk_sys);
      n++;
    end
    while (resp_valid !== 1'b1 && n < LIM);
    if (n >= LIM)
    begin
      err("no response");
      conclude();
    end
    else
    begin
      compares++;
      // The answer comes with the sequencer already idle again
      if ((resp_data & m) !== (ed & m) || resp_timeout !== et || busy !== 1'b0)
        err("response mismatch");
    end
  endtask

  initial
  begin
    clk_sys = 1'b0;
    reset = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = 3'h0;
    cmd_addr = 17'h00000;
    cmd_data = 8'h00;
    fail_count = 0;
    compares = 0;
    for (int i = 0; i < 131072; i++)
      ref_mem[i] = 8'(i * 7 + 3);
    seed_v = $urandom(32'h59a6f161);
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      a = 17'($urandom);
      run((i < 5) ? 3'h0 : 3'(i), a, 8'h00, ref_mem[a], 1'b0);
    end
    run(3'h4, a, 8'h00, ref_mem[a], 1'b0);
    run(3'h0, a ^ 17'h00001, 8'h00, ref_mem[a ^ 17'h00001], 1'b0);
    a = {3'h3, 14'($urandom)};
    run(3'h3, a, 8'h00, 8'hff, 1'b0);
    for (int i = 32'h0000c000; i < 32'h00010000; i++)
      ref_mem[i] = 8'hff;
    run(3'h0, a ^ 17'h00155, 8'h00, 8'hff, 1'b0);
    run(3'h0, a ^ 17'h04000, 8'h00, ref_mem[a ^ 17'h04000], 1'b0);
    run(3'h2, a, 8'h00, 8'hff, 1'b0);
    for (int i = 0; i < 131072; i++)
      ref_mem[i] = 8'hff;
    run(3'h0, 17'h1abcd, 8'h00, 8'hff, 1'b0);
    for (int i = 0; i < 6; i++)
    begin
      a = 17'($urandom);
      d = 8'($urandom) & ref_mem[a];
      run(3'h1, a, d, d, 1'b0);
      ref_mem[a] = d;
      run(3'h0, a, 8'h00, d, 1'b0);
    end
    a = 17'h15a5a;
    run(3'h1, a, 8'h0f, 8'h0f, 1'b0);
    run(3'h1, a, 8'hf0, 8'h20, 1'b1, 8'ha0);
    run(3'h0, a, 8'h00, 8'h00, 1'b0);
    conclude();
  end
endmodule
